// File: include/hbop_pkg.sv
// Purpose: shared constants and carriers for the host byte order port
// Assumes: 16-bit multiplexed host data bus, byte lanes high and low
// Notes:   format strap high selects big-endian host organisation
package hbop_pkg;
   localparam int          HBOP_REG_COUNT   = 8;        // directly accessible registers
   localparam int          HBOP_ADDR_W      = 3;        // register index width
   localparam int          HBOP_CNT_W       = 16;       // dma byte count width
   localparam int          HBOP_HADDR_W     = 32;       // host dma address width
   localparam logic [15:0] HBOP_REG_RST     = 16'h0000; // register reset value
   localparam logic        HBOP_FMT_BIG     = 1'b1;     // strap level for big-endian
   localparam logic [1:0]  HBOP_BUF_DEPTH   = 2'h2;     // skid buffer entries
   localparam logic [15:0] HBOP_ONE         = 16'h0001;

   // kinds of dma work the channel carries
   typedef enum logic [3:0] {
      HBOP_K_CMD    = 4'h1,
      HBOP_K_PARAM  = 4'h2,
      HBOP_K_STATUS = 4'h4,
      HBOP_K_FRAME  = 4'h8
   } hbop_kind_t;

   // dma controller states
   typedef enum logic [2:0] {
      HBOP_S_IDLE = 3'h1,
      HBOP_S_RUN  = 3'h2,
      HBOP_S_DONE = 3'h4
   } hbop_state_t;

   // one host bus lane pair
   typedef struct packed {
      logic [7:0] high;  // host_lane_high
      logic [7:0] low;   // host_lane_low
   } hbop_lanes_t;

   // one dma beat toward the host
   typedef struct packed {
      logic [HBOP_HADDR_W-1:0] addr;
      hbop_lanes_t             lanes;
      logic                    hi_en;
      logic                    lo_en;
   } hbop_beat_t;
endpackage

// File: core/hbop_skid.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   in_ready falls only when both entries hold data
`timescale 1ns/10ps
module hbop_skid
   import hbop_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk,       // clock
   input  wire logic         reset_n,   // async reset, active low
   input  wire logic         in_valid,  // source offers word
   output logic              in_ready,  // buffer accepts word
   input  wire logic [W-1:0] in_data,   // word in
   output logic              out_valid, // word available
   input  wire logic         out_ready, // sink takes word
   output logic [W-1:0]      out_data   // word out
);
   logic [W-1:0] mem_q [2];
   logic [W-1:0] mem_d [2];
   logic         wp_q, wp_d, rp_q, rp_d;
   logic [1:0]   cnt_q, cnt_d;
   logic         push, pop;

   // pointer and count update
   always_comb begin
      push     = in_valid && (cnt_q != HBOP_BUF_DEPTH);
      pop      = out_ready && (cnt_q != 2'h0);
      mem_d    = mem_q;
      wp_d     = wp_q;
      rp_d     = rp_q;
      cnt_d    = cnt_q;
      if (push) begin
         mem_d[wp_q] = in_data;
         wp_d        = ~wp_q;
      end
      if (pop) begin
         rp_d = ~rp_q;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'h1;
      end
      in_ready  = (cnt_q != HBOP_BUF_DEPTH);
      out_valid = (cnt_q != 2'h0);
      out_data  = mem_q[rp_q];
   end

   // state registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         cnt_q    <= 2'h0;
      end else begin
         mem_q <= mem_d;
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// File: core/hbop_port.sv
// Purpose: host-side byte lane and byte order logic of the adapter
// Assumes: host bus strobes and data synchronous to CLK
// Notes:   register access never swaps; dma swaps only in little-endian
`timescale 1ns/10ps
// Functional notes
// - eight host registers plus one dma channel
// - registers carry init, interrupt cause, adapter interrupts
// - network data moves only by dma
// - word write: high lane msb, low lane lsb
// - byte access order follows selected host format
// - dma bytes ascend from base until count
// - commands, parameters, lists fetched through dma
// - command and status blocks only by dma
// - little-endian dma swaps bytes in word
// - strap pin selects host byte order
// - no byte swap on register access
// - little-endian dma: byte n low lane
module hbop_port
   import hbop_pkg::*;
(
   input  wire logic                    CLK,           // 40 MHz clock
   input  wire logic                    RESET_N,       // async reset, active low
   input  wire logic                    FMT_STRAP,     // high: big-endian host
   input  wire logic                    REG_WR,        // register write strobe
   input  wire logic                    REG_RD,        // register read strobe
   input  wire logic [HBOP_ADDR_W-1:0]  REG_ADDR,      // register index
   input  wire logic                    REG_HI_EN,     // high lane strobe
   input  wire logic                    REG_LO_EN,     // low lane strobe
   input  wire logic [15:0]             REG_WDATA,     // {high lane, low lane}
   output logic [15:0]                  REG_RDATA,     // {high lane, low lane}
   output logic                         REG_RVALID,    // read data valid
   output logic [HBOP_REG_COUNT*16-1:0] REG_FILE,      // all register values
   input  wire logic                    DMA_START,     // start a dma run
   input  wire logic [3:0]              DMA_KIND,      // work kind, one-hot
   input  wire logic [HBOP_HADDR_W-1:0] DMA_BASE,      // host base address
   input  wire logic [HBOP_CNT_W-1:0]   DMA_COUNT,     // bytes to move
   input  wire logic                    SRC_VALID,     // adapter word offered
   output logic                         SRC_READY,     // adapter word taken
   input  wire logic [15:0]             SRC_DATA,      // byte n msb, byte n+1 lsb
   output logic                         HOST_VALID,    // host beat valid
   input  wire logic                    HOST_READY,    // host accepts beat
   output logic [HBOP_HADDR_W-1:0]      HOST_ADDR,     // host byte address
   output logic [15:0]                  HOST_LANES,    // {high lane, low lane}
   output logic                         HOST_HI_EN,    // high lane used
   output logic                         HOST_LO_EN,    // low lane used
   output logic                         BIG_ENDIAN,    // latched host format
   output logic                         DMA_BUSY,      // dma run in progress
   output logic                         DMA_DONE       // one-cycle run end
);
   logic [15:0]             regs_q [HBOP_REG_COUNT];
   logic [15:0]             regs_d [HBOP_REG_COUNT];
   logic [15:0]             rdata_q, rdata_d;
   logic                    rvalid_q, rvalid_d;
   logic                    byte_half_q, byte_half_d;
   logic                    strap_taken_q, strap_taken_d;
   logic                    big_q, big_d;
   hbop_state_t             st_q, st_d;
   logic [HBOP_HADDR_W-1:0] addr_q, addr_d;
   logic [HBOP_CNT_W-1:0]   left_q, left_d;
   logic                    done_q, done_d;
   hbop_beat_t              beat;
   hbop_beat_t              out_beat;
   logic                    buf_in_ready;
   logic                    buf_out_valid;
   logic                    take;
   logic [15:0]             byte_pack;
   logic [7:0]              bsel;

   // register access: lanes map straight, no swap in either format
   always_comb begin
      regs_d      = regs_q;
      rdata_d     = rdata_q;
      rvalid_d    = REG_RD;
      byte_half_d = byte_half_q;
      bsel        = REG_HI_EN ? REG_WDATA[15:8] : REG_WDATA[7:0];
      if (REG_WR && REG_HI_EN && REG_LO_EN) begin
         regs_d[REG_ADDR] = REG_WDATA;
         byte_half_d      = 1'b0;
      end else if (REG_WR) begin
         // byte host: offset +0 first, meaning depends on format
         if (byte_half_q == 1'b0) begin
            if (big_q) begin
               regs_d[REG_ADDR][15:8] = bsel;
            end else begin
               regs_d[REG_ADDR][7:0] = bsel;
            end
         end else begin
            if (big_q) begin
               regs_d[REG_ADDR][7:0] = bsel;
            end else begin
               regs_d[REG_ADDR][15:8] = bsel;
            end
         end
         byte_half_d = ~byte_half_q;
      end
      if (REG_RD) begin
         rdata_d = regs_q[REG_ADDR];
      end
   end

   // strap caught on the first clock after reset release
   always_comb begin
      strap_taken_d = 1'b1;
      big_d         = strap_taken_q ? big_q : (FMT_STRAP == HBOP_FMT_BIG);
   end

   // dma sequencer: ascending bytes from base until count
   always_comb begin
      st_d   = st_q;
      addr_d = addr_q;
      left_d = left_q;
      done_d = 1'b0;
      take   = 1'b0;
      case (st_q)
         HBOP_S_IDLE: begin
            // commands, parameters, blocks and frames all use this path
            if (DMA_START && DMA_KIND != 4'h0 && DMA_COUNT != '0) begin
               addr_d = DMA_BASE;
               left_d = DMA_COUNT;
               st_d   = HBOP_S_RUN;
            end
         end
         HBOP_S_RUN: begin
            take = SRC_VALID && buf_in_ready;
            if (take) begin
               if (left_q == HBOP_ONE || addr_q[0]) begin
                  addr_d = addr_q + HBOP_HADDR_W'(1);
                  left_d = left_q - HBOP_ONE;
               end else begin
                  addr_d = addr_q + HBOP_HADDR_W'(2);
                  left_d = left_q - 16'h0002;
               end
               if (left_d == '0) begin
                  st_d = HBOP_S_DONE;
               end
            end
         end
         HBOP_S_DONE: begin
            done_d = 1'b1;
            st_d   = HBOP_S_IDLE;
         end
         default: st_d = HBOP_S_IDLE;
      endcase
   end

   // lane placement: swap within the word only for little-endian dma
   always_comb begin
      byte_pack = big_q ? SRC_DATA : {SRC_DATA[7:0], SRC_DATA[15:8]};
      beat.addr  = addr_q;
      beat.lanes = byte_pack;
      if (left_q == HBOP_ONE || addr_q[0]) begin
         // single byte: even address is high lane if big, low lane if little
         beat.lanes = {SRC_DATA[15:8], SRC_DATA[15:8]};
         beat.hi_en = (addr_q[0] != big_q);
         beat.lo_en = (addr_q[0] == big_q);
      end else begin
         beat.hi_en = 1'b1;
         beat.lo_en = 1'b1;
      end
   end

   hbop_skid #(
      .W($bits(hbop_beat_t))
   ) u_skid (
      .clk       (CLK),
      .reset_n   (RESET_N),
      .in_valid  (take),
      .in_ready  (buf_in_ready),
      .in_data   (beat),
      .out_valid (buf_out_valid),
      .out_ready (HOST_READY),
      .out_data  (out_beat)
   );

   // state registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int i = 0; i < HBOP_REG_COUNT; i++) begin
            regs_q[i] <= HBOP_REG_RST;
         end
         rdata_q       <= 16'h0000;
         rvalid_q      <= 1'b0;
         byte_half_q   <= 1'b0;
         strap_taken_q <= 1'b0;
         big_q         <= 1'b1;
         st_q          <= HBOP_S_IDLE;
         addr_q        <= '0;
         left_q        <= '0;
         done_q        <= 1'b0;
      end else begin
         regs_q        <= regs_d;
         rdata_q       <= rdata_d;
         rvalid_q      <= rvalid_d;
         byte_half_q   <= byte_half_d;
         strap_taken_q <= strap_taken_d;
         big_q         <= big_d;
         st_q          <= st_d;
         addr_q        <= addr_d;
         left_q        <= left_d;
         done_q        <= done_d;
      end
   end

   // output drive; skid outputs are flop-held inside the buffer
   always_comb begin
      for (int i = 0; i < HBOP_REG_COUNT; i++) begin
         REG_FILE[i*16 +: 16] = regs_q[i];
      end
      REG_RDATA  = rdata_q;
      REG_RVALID = rvalid_q;
      SRC_READY  = (st_q == HBOP_S_RUN) && buf_in_ready;
      HOST_VALID = buf_out_valid;
      HOST_ADDR  = out_beat.addr;
      HOST_LANES = out_beat.lanes;
      HOST_HI_EN = out_beat.hi_en;
      HOST_LO_EN = out_beat.lo_en;
      BIG_ENDIAN = big_q;
      DMA_BUSY   = (st_q != HBOP_S_IDLE);
      DMA_DONE   = done_q;
   end

   a_word_write_lanes: assert property (@(posedge CLK) disable iff (!RESET_N)
      (REG_WR && REG_HI_EN && REG_LO_EN) |=> regs_q[$past(REG_ADDR)] == $past(REG_WDATA))
      else $error("word write lane mapping wrong");
   a_read_lanes: assert property (@(posedge CLK) disable iff (!RESET_N)
      (REG_RD && !REG_WR) |=> (REG_RVALID && REG_RDATA == regs_q[$past(REG_ADDR)]))
      else $error("read lane mapping wrong");
   a_format_held: assert property (@(posedge CLK) disable iff (!RESET_N)
      strap_taken_q |=> $stable(big_q))
      else $error("host format changed after reset");
   a_dma_swap: assert property (@(posedge CLK) disable iff (!RESET_N)
      (!big_q && take && beat.hi_en && beat.lo_en) |-> beat.lanes == {SRC_DATA[7:0], SRC_DATA[15:8]})
      else $error("little-endian dma not swapped");
   a_dma_noswap: assert property (@(posedge CLK) disable iff (!RESET_N)
      (big_q && take && beat.hi_en && beat.lo_en) |-> beat.lanes == SRC_DATA)
      else $error("big-endian dma swapped");
   a_single_lane: assert property (@(posedge CLK) disable iff (!RESET_N)
      (take && !(beat.hi_en && beat.lo_en))
      |-> (beat.hi_en == (addr_q[0] != big_q) && beat.hi_en != beat.lo_en
           && (beat.hi_en ? beat.lanes.high : beat.lanes.low) == SRC_DATA[15:8]))
      else $error("single dma byte on wrong lane");
   a_dma_ascend: assert property (@(posedge CLK) disable iff (!RESET_N)
      (take && st_d == HBOP_S_RUN) |=> addr_q > $past(addr_q))
      else $error("dma address not ascending");
   a_dma_ends: assert property (@(posedge CLK) disable iff (!RESET_N)
      (st_q == HBOP_S_DONE) |=> (DMA_DONE && !DMA_BUSY))
      else $error("dma run end not signalled");
   a_byte_order: assert property (@(posedge CLK) disable iff (!RESET_N)
      (REG_WR && !(REG_HI_EN && REG_LO_EN) && !byte_half_q && big_q)
      |=> regs_q[$past(REG_ADDR)][15:8] == $past(bsel))
      else $error("big-endian first byte not msb");
endmodule

// File: testbench/hbop_host_mem.sv
// Purpose: host memory model behind the dma beat port
// Assumes: beats handshake with valid and ready on the clock
// Notes:   stall 0 prompt, 1 ready one cycle in four, 2 ready low
`timescale 1ns/10ps
module hbop_host_mem
   import hbop_pkg::*;
(
   input  wire logic                    clk,     // clock
   input  wire logic                    reset_n, // async reset, active low
   input  wire logic [1:0]              stall,   // ready pattern
   input  wire logic                    big,     // host format
   input  wire logic                    valid,   // beat offered
   output logic                         ready,   // beat taken
   input  wire logic [HBOP_HADDR_W-1:0] addr,    // byte address
   input  wire logic [15:0]             lanes,   // {high, low}
   input  wire logic                    hi_en,   // high lane used
   input  wire logic                    lo_en    // low lane used
);
   logic [7:0] mem [256];
   logic [1:0] tick_q;

   // memory starts filled with a marker
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'hEE;
   end

   // free running phase for the slow ready pattern
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) tick_q <= 2'h0;
      else tick_q <= tick_q + 2'h1;
   end
   assign ready = (stall == 2'h0) || (stall == 2'h1 && tick_q == 2'h3);

   // each lane lands at the byte address its format gives it
   always @(posedge clk) begin
      if (reset_n && valid && ready) begin
         if (hi_en) mem[{addr[7:1], !big}] <= lanes[15:8];
         if (lo_en) mem[{addr[7:1], big}] <= lanes[7:0];
      end
   end
endmodule

// File: testbench/hbop_port_test.sv
// Purpose: self-checking bench for the host byte order port
// Assumes: host memory model on the beat port, bench drives the rest
// Notes:   byte at host address x carries x xor A5
`timescale 1ns/10ps
module hbop_port_test;
   import hbop_pkg::*;
   typedef struct {logic [2:0] a; logic [15:0] wd; logic [15:0] ex;} hbop_row_t;
   logic clk, reset_n, strap, reg_wr, reg_rd, reg_hi, reg_lo, rvalid, dma_start;
   logic src_valid, src_ready, host_valid, host_ready, hi_en, lo_en;
   logic big_endian, dma_busy, dma_done, exp_big;
   logic [2:0] reg_addr;
   logic [15:0] wdata, rdata, src_data, lanes;
   logic [127:0] reg_file;
   logic [3:0] dma_kind;
   logic [31:0] dma_base, host_addr;
   logic [15:0] dma_count;
   logic [1:0] stall;
   int error_cnt, checked;
   hbop_row_t rows[8] = '{'{0, 16'h55AA, 16'h55AA}, '{1, 16'h0001, 16'h0001},
      '{2, 16'hFF00, 16'hFF00}, '{3, 16'h8001, 16'h8001}, '{4, 16'h1234, 16'h1234},
      '{5, 16'hA5C3, 16'hA5C3}, '{6, 16'h7FFE, 16'h7FFE}, '{7, 16'hFFFF, 16'hFFFF}};
   logic [7:0] bases[4] = '{8'h10, 8'h21, 8'h30, 8'h60};
   logic [7:0] cnts[4] = '{8'h04, 8'h05, 8'h03, 8'h0A};
   logic [1:0] stalls[4] = '{2'h0, 2'h1, 2'h0, 2'h2};

   hbop_port dut (.CLK(clk), .RESET_N(reset_n), .FMT_STRAP(strap), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_HI_EN(reg_hi), .REG_LO_EN(reg_lo),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_FILE(reg_file),
      .DMA_START(dma_start), .DMA_KIND(dma_kind), .DMA_BASE(dma_base),
      .DMA_COUNT(dma_count), .SRC_VALID(src_valid), .SRC_READY(src_ready),
      .SRC_DATA(src_data), .HOST_VALID(host_valid), .HOST_READY(host_ready),
      .HOST_ADDR(host_addr), .HOST_LANES(lanes), .HOST_HI_EN(hi_en),
      .HOST_LO_EN(lo_en), .BIG_ENDIAN(big_endian), .DMA_BUSY(dma_busy), .DMA_DONE(dma_done));
   hbop_host_mem u_host (.clk(clk), .reset_n(reset_n), .stall(stall), .big(exp_big),
      .valid(host_valid), .ready(host_ready), .addr(host_addr), .lanes(lanes),
      .hi_en(hi_en), .lo_en(lo_en));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // one register bus cycle, entered just after an edge
   task automatic reg_op(input logic wr, rd, input logic [2:0] a, input logic hi, lo,
                         input logic [15:0] d);
      {reg_wr, reg_rd, reg_addr, reg_hi, reg_lo, wdata} = {wr, rd, a, hi, lo, d};
      @(posedge clk);
      #1;
   endtask

   // reset held ten cycles, strap moved after its sampling edge
   task automatic do_reset(input logic s);
      reset_n = 1'b0;
      strap = s;
      exp_big = s;
      repeat (10) @(posedge clk);
      #1;
      chk(big_endian, 1'b1);
      chk({|reg_file, host_valid, dma_busy, dma_done, rvalid}, 5'h00);
      reset_n = 1'b1;
      @(posedge clk);
      #1;
      strap = !s;
      @(posedge clk);
      #1;
      chk(big_endian, s);
   endtask

   // one dma run fed word by word from the adapter side
   task automatic dma_run(input logic [7:0] base, cnt, input logic [3:0] kind, input logic [1:0] st);
      logic [7:0] a, left, x;
      logic tk, fin;
      int n, c;
      a = base;
      left = cnt;
      fin = 1'b0;
      c = cnt;
      stall = st;
      {dma_start, dma_kind, dma_base, dma_count} = {1'b1, kind, 24'h0, base, 8'h0, cnt};
      @(posedge clk);
      #1;
      dma_base = 32'h000000F0;
      @(posedge clk);
      #1;
      dma_start = 1'b0;
      chk(dma_busy, 1'b1);
      for (n = 0; n < 400 && !fin; n++) begin
         src_valid = (left != 8'h0);
         src_data = {a ^ 8'hA5, (a + 8'h1) ^ 8'hA5};
         if (st == 2'h2 && n == 30) begin
            chk(src_ready, 1'b0);
            stall = 2'h0;
         end
         @(negedge clk);
         tk = src_valid && src_ready;
         @(posedge clk);
         #1;
         if (tk) begin
            x = (a[0] || left == 8'h1) ? 8'h1 : 8'h2;
            a += x;
            left -= x;
         end
         if (dma_done === 1'b1) fin = 1'b1;
      end
      if (!fin) begin
         error_cnt++;
         give_verdict();
      end
      src_valid = 1'b0;
      @(posedge clk);
      #1;
      chk({dma_done, dma_busy}, 2'h0);
      for (n = 0; n < 20 && host_valid !== 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
      if (host_valid !== 1'b0) begin
         error_cnt++;
         give_verdict();
      end
      for (n = -1; n <= c; n++) begin
         x = base + 8'(n);
         chk(u_host.mem[x], (n < 0 || n == c) ? 8'hEE : x ^ 8'hA5);
      end
      chk(u_host.mem[8'hF0], 8'hEE);
   endtask

   // main sequence: both host formats in turn
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_hi, reg_lo, wdata, dma_start, dma_kind} = '0;
      {dma_base, dma_count, src_valid, src_data, stall, error_cnt, checked} = '0;
      for (int f = 0; f < 2; f++) begin
         do_reset(f == 0);
         foreach (rows[i]) begin
            reg_op(1'b1, 1'b0, rows[i].a, 1'b1, 1'b1, rows[i].wd);
            chk(reg_file[16*rows[i].a +: 16], rows[i].ex);
         end
         foreach (rows[i]) begin
            reg_op(1'b0, 1'b1, rows[i].a, 1'b0, 1'b0, 16'h0);
            chk({rvalid, rdata}, {1'b1, rows[i].ex});
         end
         // byte pairs, then a word that restarts the pairing
         reg_op(1'b1, 1'b0, 3'h3, 1'b1, 1'b1, 16'h0000);
         reg_op(1'b1, 1'b0, 3'h3, exp_big, !exp_big, 16'h55AA);
         chk(reg_file[63:48], exp_big ? 16'h5500 : 16'h00AA);
         reg_op(1'b1, 1'b0, 3'h3, !exp_big, exp_big, 16'h55AA);
         chk(reg_file[63:48], 16'h55AA);
         reg_op(1'b1, 1'b0, 3'h3, exp_big, !exp_big, 16'h55AA);
         reg_op(1'b1, 1'b0, 3'h3, 1'b1, 1'b1, 16'h1234);
         reg_op(1'b1, 1'b0, 3'h3, exp_big, !exp_big, 16'h55AA);
         reg_op(1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 16'h0);
         chk(reg_file[63:48], exp_big ? 16'h5534 : 16'h12AA);
         // zero count or no kind must not start a run
         for (int k = 0; k < 2; k++) begin
            {dma_start, dma_kind, dma_count} = {1'b1, k ? 4'h0 : 4'h1, k ? 16'h4 : 16'h0};
            @(posedge clk);
            #1;
            dma_start = 1'b0;
            @(posedge clk);
            #1;
            chk(dma_busy, 1'b0);
         end
         for (int k = 0; k < 4; k++) begin
            dma_run(bases[k] + (f ? 8'h80 : 8'h00), cnts[k], 4'h1 << k, stalls[k]);
         end
      end
      give_verdict();
   end
endmodule
